// *** pdmux_jtag_host.sv ***
// Behavioural test-port controller standing at the far side of the mux.
// Assumes the bench resolves the pins and feeds back the data-out pin level.
`timescale 1ns/1ns
`default_nettype none

module pdmux_jtag_host (
  // Test port pins
  output logic      test_clk_drv,
  output logic      tms_drv,
  output logic      tdi_drv,
  // Resolved data-out pin, pulled up
  input  wire logic tdo_lvl
);
  // Clock parked low between frames, data in held high; mode select starts high but is left low after each frame
  initial begin
    test_clk_drv = 1'b0;
    tms_drv = 1'b1;
    tdi_drv = 1'b1;
  end

  // One 6 ns test clock period; data out taken at the rise
  task automatic tick(input logic m, input logic d, output logic q);
    tms_drv = m;
    tdi_drv = d;
    #3 test_clk_drv = 1'b1;
    q = tdo_lvl;
    #3 test_clk_drv = 1'b0;
  endtask

  // Five mode-select highs always land in test-logic reset, then idle
  task automatic reset();
    logic q;
    repeat (5) tick(1'b1, 1'b1, q);
    tick(1'b0, 1'b1, q);
  endtask

  // Idle to shift, four bits LSB first, update, back to idle
  task automatic scan(input logic ir, input logic [3:0] din,
                      output logic [3:0] dout);
    logic q;
    tick(1'b1, 1'b1, q);
    if (ir) begin
      tick(1'b1, 1'b1, q);
    end
    tick(1'b0, 1'b1, q);
    tick(1'b0, 1'b1, q);
    for (int i = 0; i < 4; i++) begin
      tick(i == 3, din[i], dout[i]);
    end
    tick(1'b1, 1'b1, q);
    tick(1'b0, 1'b1, q);
  endtask
endmodule

`default_nettype wire

// *** pdmux_top.sv ***
// Port D pin mux with test port: package, top module and its checks.
// Assumes pad cells resolve pad_out/pad_oe_n; test_clk is the TCK pad.

// Overview of operation
// [R01] In GPIO mode software sets each pin's direction as input or output.
// [R02] After reset crystal and both DAC pins come up as plain GPIO.
// [R03] After reset four shared pins serve the test port; GPIO is alternate.
// [R04] Test data in is sampled on each rising test clock edge.
// [R05] Controller drives mode select; device samples it on rising edges.
// [R06] Test data out driven only in Shift-IR or Shift-DR, else released.
// [R07] Test data out changes only on falling test clock edges.
// [R08] Controller gates the test clock; shifting happens only while it toggles.
// [R09] Crystal pin in clock-input function is routed to the clock logic.
// [R10] Per-pin function select written by software, reset gives defaults.

package pdmux_pkg;
  localparam int          PINS      = 8;
  localparam logic [7:0]  SEL_RST   = 8'h0F;
  localparam int          PIN_TDI   = 0;
  localparam int          PIN_TDO   = 1;
  localparam int          PIN_TMS   = 3;
  localparam int          PIN_CRYSTAL_DRIVE_OUT  = 5;
  localparam int          PIN_ANALOG_OUT_ZERO  = 6;
  localparam int          PIN_ANALOG_OUT_ONE  = 7;
  localparam logic [3:0]  IR_RST    = 4'hF;
  localparam logic [3:0]  IR_CAPT   = 4'h1;
  typedef enum logic [3:0] {
    TS_RESET  = 4'h0, TS_IDLE   = 4'h1, TS_SEL_DR = 4'h2, TS_CAP_DR = 4'h3,
    TS_SH_DR  = 4'h4, TS_EX1_DR = 4'h5, TS_PA_DR  = 4'h6, TS_EX2_DR = 4'h7,
    TS_UP_DR  = 4'h8, TS_SEL_IR = 4'h9, TS_CAP_IR = 4'hA, TS_SH_IR  = 4'hB,
    TS_EX1_IR = 4'hC, TS_PA_IR  = 4'hD, TS_EX2_IR = 4'hE, TS_UP_IR  = 4'hF
  } pdmux_tap_t;
endpackage

`timescale 1ns/1ns
`default_nettype none

module pdmux_top (
  // System clock and reset
  input  wire logic       ref_clk,
  input  wire logic       sys_rst,
  // Test clock from the pin
  input  wire logic       test_clk,
  // Software control
  input  wire logic [7:0] func_sel_wdata,
  input  wire logic       func_sel_wr,
  input  wire logic [7:0] gpio_dir,
  input  wire logic [7:0] gpio_out,
  input  wire logic       external_clock_in_mode,
  // Software status
  output logic      [7:0] func_sel,
  output logic      [7:0] gpio_in,
  output logic      [3:0] test_ir,
  // Pads
  input  wire logic [7:0] pad_in,
  output logic      [7:0] pad_out,
  output logic      [7:0] pad_oe_n,
  // Analog and clock functions
  output logic            crystal_drive_out_en,
  output logic            external_clock_in,
  output logic            analog_out_zero_en,
  output logic            analog_out_one_en
);

  typedef struct packed {
    logic [7:0] sel;
    logic [7:0] out;
    logic [7:0] oe_n;
    logic [7:0] p_s1;
    logic [7:0] p_s2;
    logic       tog_s1;
    logic       tog_s2;
    logic       tog_s3;
    logic [3:0] ir;
    logic [2:0] ana;
  } pdmux_ref_t;

  typedef struct packed {
    pdmux_pkg::pdmux_tap_t st;
    logic [3:0]            ir;
    logic [3:0]            ir_sh;
    logic                  byp;
    logic                  tog;
    logic                  rst_s1;
    logic                  rst_s2;
    logic                  en_s1;
    logic                  en_s2;
  } pdmux_tck_t;

  typedef struct packed {
    logic tdo;
    logic oe;
  } pdmux_neg_t;

  pdmux_ref_t r_r, r_nxt;
  pdmux_tck_t t_r, t_nxt;
  pdmux_neg_t n_r, n_nxt;
  logic       tap_rst;
  logic       tdi;
  logic       tms;
  logic       shifting;

  assign tdi      = pad_in[pdmux_pkg::PIN_TDI];
  assign tms      = pad_in[pdmux_pkg::PIN_TMS];
  // Port held in reset whenever the pins are not all in test function
  assign tap_rst  = t_r.rst_s2 | ~t_r.en_s2;
  assign shifting = (t_r.st == pdmux_pkg::TS_SH_IR) ||
                    (t_r.st == pdmux_pkg::TS_SH_DR);

  // System clock domain
  always_comb begin
    r_nxt        = r_r;
    r_nxt.p_s1   = pad_in;
    r_nxt.p_s2   = r_r.p_s1;
    r_nxt.tog_s1 = t_r.tog;
    r_nxt.tog_s2 = r_r.tog_s1;
    r_nxt.tog_s3 = r_r.tog_s2;
    // IR is stable two edges before the toggle is seen here
    if (r_r.tog_s2 != r_r.tog_s3) begin
      r_nxt.ir = t_r.ir;
    end
    if (func_sel_wr) begin
      r_nxt.sel = func_sel_wdata; // [R10]
    end
    for (int k = 0; k < pdmux_pkg::PINS; k++) begin
      r_nxt.oe_n[k] = r_nxt.sel[k] | ~gpio_dir[k]; // [R01]
      r_nxt.out[k]  = ~r_nxt.sel[k] & gpio_out[k];
    end
    r_nxt.ana[0] = r_nxt.sel[pdmux_pkg::PIN_CRYSTAL_DRIVE_OUT] & ~external_clock_in_mode;
    r_nxt.ana[1] = r_nxt.sel[pdmux_pkg::PIN_ANALOG_OUT_ZERO];
    r_nxt.ana[2] = r_nxt.sel[pdmux_pkg::PIN_ANALOG_OUT_ONE];
    if (sys_rst) begin
      r_nxt     = '0;
      r_nxt.sel = pdmux_pkg::SEL_RST; // [R02] [R03]
      r_nxt.oe_n = 8'hFF;
    end
  end

  always_ff @(posedge ref_clk) begin
    r_r <= r_nxt;
  end

  // Test clock domain, rising edge; gated clock, no edges outside frames
  always_comb begin
    t_nxt        = t_r;
    t_nxt.rst_s1 = sys_rst;
    t_nxt.rst_s2 = t_r.rst_s1;
    t_nxt.en_s1  = &r_r.sel[3:0];
    t_nxt.en_s2  = t_r.en_s1;
    if (tap_rst) begin
      t_nxt.st    = pdmux_pkg::TS_RESET;
      t_nxt.ir    = pdmux_pkg::IR_RST;
      t_nxt.ir_sh = pdmux_pkg::IR_RST;
      t_nxt.byp   = 1'b0;
      t_nxt.tog   = 1'b0;
    end else begin
      case (t_r.st) // [R05]
        pdmux_pkg::TS_RESET:  t_nxt.st = tms ? pdmux_pkg::TS_RESET
                                             : pdmux_pkg::TS_IDLE;
        pdmux_pkg::TS_IDLE:   t_nxt.st = tms ? pdmux_pkg::TS_SEL_DR
                                             : pdmux_pkg::TS_IDLE;
        pdmux_pkg::TS_SEL_DR: t_nxt.st = tms ? pdmux_pkg::TS_SEL_IR
                                             : pdmux_pkg::TS_CAP_DR;
        pdmux_pkg::TS_CAP_DR: t_nxt.st = tms ? pdmux_pkg::TS_EX1_DR
                                             : pdmux_pkg::TS_SH_DR;
        pdmux_pkg::TS_SH_DR:  t_nxt.st = tms ? pdmux_pkg::TS_EX1_DR
                                             : pdmux_pkg::TS_SH_DR;
        pdmux_pkg::TS_EX1_DR: t_nxt.st = tms ? pdmux_pkg::TS_UP_DR
                                             : pdmux_pkg::TS_PA_DR;
        pdmux_pkg::TS_PA_DR:  t_nxt.st = tms ? pdmux_pkg::TS_EX2_DR
                                             : pdmux_pkg::TS_PA_DR;
        pdmux_pkg::TS_EX2_DR: t_nxt.st = tms ? pdmux_pkg::TS_UP_DR
                                             : pdmux_pkg::TS_SH_DR;
        pdmux_pkg::TS_SEL_IR: t_nxt.st = tms ? pdmux_pkg::TS_RESET
                                             : pdmux_pkg::TS_CAP_IR;
        pdmux_pkg::TS_CAP_IR: t_nxt.st = tms ? pdmux_pkg::TS_EX1_IR
                                             : pdmux_pkg::TS_SH_IR;
        pdmux_pkg::TS_SH_IR:  t_nxt.st = tms ? pdmux_pkg::TS_EX1_IR
                                             : pdmux_pkg::TS_SH_IR;
        pdmux_pkg::TS_EX1_IR: t_nxt.st = tms ? pdmux_pkg::TS_UP_IR
                                             : pdmux_pkg::TS_PA_IR;
        pdmux_pkg::TS_PA_IR:  t_nxt.st = tms ? pdmux_pkg::TS_EX2_IR
                                             : pdmux_pkg::TS_PA_IR;
        pdmux_pkg::TS_EX2_IR: t_nxt.st = tms ? pdmux_pkg::TS_UP_IR
                                             : pdmux_pkg::TS_SH_IR;
        pdmux_pkg::TS_UP_DR,
        pdmux_pkg::TS_UP_IR:  t_nxt.st = tms ? pdmux_pkg::TS_SEL_DR
                                             : pdmux_pkg::TS_IDLE;
        default:              t_nxt.st = pdmux_pkg::TS_RESET;
      endcase
      case (t_r.st) // [R04] [R08]
        pdmux_pkg::TS_RESET: begin
          t_nxt.ir  = pdmux_pkg::IR_RST;
          t_nxt.tog = 1'b0;
        end
        pdmux_pkg::TS_CAP_DR: t_nxt.byp   = 1'b0;
        pdmux_pkg::TS_SH_DR:  t_nxt.byp   = tdi;
        pdmux_pkg::TS_CAP_IR: t_nxt.ir_sh = pdmux_pkg::IR_CAPT;
        pdmux_pkg::TS_SH_IR:  t_nxt.ir_sh = {tdi, t_r.ir_sh[3:1]};
        pdmux_pkg::TS_UP_IR: begin
          t_nxt.ir  = t_r.ir_sh;
          t_nxt.tog = ~t_r.tog;
        end
        default: t_nxt.byp = t_r.byp;
      endcase
    end
  end

  always_ff @(posedge test_clk) begin
    t_r <= t_nxt;
  end

  // Falling edge stage keeps TDO steady across the controller's sample
  always_comb begin
    n_nxt.oe  = shifting & ~tap_rst; // [R06]
    n_nxt.tdo = (t_r.st == pdmux_pkg::TS_SH_IR) ? t_r.ir_sh[0] : t_r.byp;
  end

  always_ff @(negedge test_clk) begin
    n_r <= n_nxt; // [R07]
  end

  // Pad drive; each bit written once so pin 1 never glitches
  always_comb begin
    for (int k = 0; k < pdmux_pkg::PINS; k++) begin
      if (k == pdmux_pkg::PIN_TDO && r_r.sel[k]) begin
        pad_out[k]  = n_r.tdo;
        pad_oe_n[k] = ~n_r.oe; // [R06]
      end else begin
        pad_out[k]  = r_r.out[k];
        pad_oe_n[k] = r_r.oe_n[k];
      end
    end
  end

  assign func_sel             = r_r.sel;
  assign gpio_in              = r_r.p_s2;
  assign test_ir              = r_r.ir;
  assign crystal_drive_out_en = r_r.ana[0];
  assign analog_out_zero_en   = r_r.ana[1];
  assign analog_out_one_en    = r_r.ana[2];
  // A clock, so passed straight through rather than synchronised
  assign external_clock_in    = pad_in[pdmux_pkg::PIN_CRYSTAL_DRIVE_OUT] & // [R09]
                                r_r.sel[pdmux_pkg::PIN_CRYSTAL_DRIVE_OUT] & external_clock_in_mode;

  sequence s_five_tms;
    tms [*5];
  endsequence

  AST_TDO_OE_SHIFT: assert property ( // [R06]
    @(posedge test_clk) disable iff (tap_rst) shifting |-> n_r.oe)
    else $error("TDO not enabled in a shift state");

  AST_TDO_OE_IDLE: assert property ( // [R06]
    @(posedge test_clk) disable iff (tap_rst) !shifting |-> !n_r.oe)
    else $error("TDO enable outside shift states");

  AST_TDO_NEG_DATA: assert property ( // [R07]
    @(posedge test_clk) disable iff (tap_rst)
    (t_r.st == pdmux_pkg::TS_SH_IR) |-> n_r.tdo == t_r.ir_sh[0])
    else $error("TDO not set up on the falling edge");

  AST_TMS_STEP: assert property ( // [R05]
    @(posedge test_clk) disable iff (tap_rst)
    (t_r.st == pdmux_pkg::TS_IDLE && tms) |=> t_r.st == pdmux_pkg::TS_SEL_DR)
    else $error("TMS did not step idle to select-DR");

  AST_TMS_RESET: assert property ( // [R05]
    @(posedge test_clk) disable iff (tap_rst)
    s_five_tms |=> t_r.st == pdmux_pkg::TS_RESET)
    else $error("Five TMS highs did not reach reset");

  AST_TDI_SAMPLE: assert property ( // [R04]
    @(posedge test_clk) disable iff (tap_rst)
    (t_r.st == pdmux_pkg::TS_SH_IR) |=> t_r.ir_sh[3] == $past(tdi))
    else $error("TDI not shifted on the rising edge");

  AST_RESET_FUNC: assert property ( // [R02] [R03]
    @(posedge ref_clk) sys_rst |=> func_sel == pdmux_pkg::SEL_RST &&
    !analog_out_zero_en && !analog_out_one_en && !crystal_drive_out_en)
    else $error("Pin functions wrong after reset");

  AST_GPIO_DIR: assert property ( // [R01]
    @(posedge ref_clk) disable iff (sys_rst)
    (!func_sel_wr && !func_sel[pdmux_pkg::PIN_ANALOG_OUT_ZERO] &&
     gpio_dir[pdmux_pkg::PIN_ANALOG_OUT_ZERO]) |=> !pad_oe_n[pdmux_pkg::PIN_ANALOG_OUT_ZERO])
    else $error("GPIO output direction not applied");

  AST_SEL_WRITE: assert property ( // [R10]
    @(posedge ref_clk) disable iff (sys_rst)
    func_sel_wr |=> func_sel == $past(func_sel_wdata))
    else $error("Function select write lost");

endmodule

`default_nettype wire

// *** tb_port_d_pin_mux_with_jtag.sv ***
// Self-checking bench for the port D mux with its test port.
// Assumes pdmux_top and pdmux_jtag_host; pins resolved here with pull-ups.
`timescale 1ns/1ns
`default_nettype none

module tb_port_d_pin_mux_with_jtag;
  logic            ref_clk = 1'b0;
  logic            sys_rst = 1'b1;
  logic            wr = 1'b0;
  logic            ckm = 1'b0;
  logic            chk_edge = 1'b0;
  logic      [7:0] wdata = 8'h00;
  logic      [7:0] dir = 8'h00;
  logic      [7:0] gout = 8'h00;
  logic      [7:0] ext_r = 8'h00;
  logic      [7:0] e_oe, e_pad, m;
  logic      [3:0] din, dout;
  wire logic [7:0] fsel, gin, pout, poe_n, pad, ext_lvl;
  wire logic [3:0] tir;
  wire logic       tck, tms, tdi, xen, xck, a0, a1;
  integer          seed = 36;
  int              n_mismatch = 0;
  int              comparisons = 0;

  always #4 ref_clk = ~ref_clk;
  // Released pins fall back to the far side or the pull-up
  assign ext_lvl = {ext_r[7:4], tms, tck, 1'b1, tdi};
  assign pad = (~poe_n & pout) | (poe_n & ext_lvl);

  pdmux_top dut (.ref_clk(ref_clk), .sys_rst(sys_rst), .test_clk(pad[2]),
    .func_sel_wdata(wdata), .func_sel_wr(wr), .gpio_dir(dir),
    .gpio_out(gout), .external_clock_in_mode(ckm), .func_sel(fsel), .gpio_in(gin),
    .test_ir(tir), .pad_in(pad), .pad_out(pout), .pad_oe_n(poe_n),
    .crystal_drive_out_en(xen), .external_clock_in(xck),
    .analog_out_zero_en(a0), .analog_out_one_en(a1));
  pdmux_jtag_host host (.test_clk_drv(tck), .tms_drv(tms), .tdi_drv(tdi),
    .tdo_lvl(pad[1]));

  task automatic cmp(input string nm, input logic [7:0] e, input logic [7:0] g);
    comparisons++;
    if (g !== e) begin
      n_mismatch++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask

  // Expected drive enables: released unless GPIO function and output
  function automatic logic [7:0] exp_oe_n(input logic [7:0] s,
                                          input logic [7:0] d);
    return s | ~d;
  endfunction

  task automatic wr_sel(input logic [7:0] v);
    wdata = v;
    wr = 1'b1;
    @(posedge ref_clk);
    #1 wr = 1'b0;
  endtask

  task automatic final_report();
    if (n_mismatch == 0 && comparisons > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  // Data out may only move while the test clock is low
  always @(pout[1] or poe_n[1]) begin
    if (chk_edge) cmp("tdo_edge", 8'h00, {7'h00, tck});
  end

  initial begin
    #100000 n_mismatch++;
    final_report();
  end

  initial begin
    repeat (5) @(posedge ref_clk);
    #1;
    cmp("func_sel_rst", 8'h0F, fsel);
    cmp("analog_rst", 8'h00, {5'h00, a1, a0, xen});
    cmp("oe_rst", 8'hFF, poe_n);
    sys_rst = 1'b0;
    // All-GPIO and all-peripheral first, then random mixes
    for (int i = 0; i < 40; i++) begin
      dir = 8'($random(seed));
      gout = 8'($random(seed));
      ext_r = 8'($random(seed));
      ckm = 1'($random(seed));
      wr_sel(i == 0 ? 8'h00 : i == 1 ? 8'hFF : 8'($random(seed)));
      cmp("func_sel", wdata, fsel);
      repeat (3) @(posedge ref_clk);
      #1;
      m = ~(wdata & 8'h02);
      e_oe = exp_oe_n(wdata, dir);
      e_pad = (~e_oe & gout) | (e_oe & ext_lvl);
      cmp("pad_oe_n", e_oe & m, poe_n & m);
      cmp("pad_out", ~wdata & gout & m, pout & m);
      cmp("gpio_in", e_pad & m, gin & m);
      cmp("analog_clk", {4'h0, wdata[7], wdata[6], wdata[5] & ~ckm,
          e_pad[5] & wdata[5] & ckm}, {4'h0, a1, a0, xen, xck});
    end
    wr_sel(8'($random(seed)) | 8'h0F);
    host.reset();
    chk_edge = 1'b1;
    for (int j = 0; j < 4; j++) begin
      din = j == 0 ? 4'h0 : j == 1 ? 4'hF : 4'($random(seed));
      host.scan(1'b1, din, dout);
      cmp("ir_capture", 8'h01, {4'h0, dout});
      repeat (8) @(posedge ref_clk);
      #1;
      cmp("test_ir", {4'h0, din}, {4'h0, tir});
      host.scan(1'b0, din, dout);
      cmp("bypass", {4'h0, din[2:0], 1'b0}, {4'h0, dout});
      cmp("tdo_released", 8'h01, {7'h00, poe_n[1]});
    end
    final_report();
  end
endmodule

`default_nettype wire
